// *** hdl/cisa_add_sub.sv ***
/*
  32-bit adder and subtractor with carry and signed overflow.
  Assumes subtraction carry means no borrow, as the status flags expect.
*/
`timescale 1ns/1ps
module cisa_add_sub (
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic        subtract,
  output logic      [31:0] sum,
  output logic             carry,
  output logic             overflow
);

  logic [31:0] b_eff;
  logic [32:0] wide;

  always_comb begin
    b_eff    = subtract ? ~op_b : op_b;
    wide     = {1'b0, op_a} + {1'b0, b_eff} + {32'h0, subtract};
    sum      = wide[31:0];
    carry    = wide[32];
    overflow = (op_a[31] == b_eff[31]) && (wide[31] != op_a[31]);
  end

endmodule

// *** hdl/cisa_barrel_shifter.sv ***
/*
  Immediate barrel shifter: logical left by 0..31, logical right and arithmetic right by 1..32.
  Assumes the caller supplies the current carry flag for the unshifted left case.
*/
`timescale 1ns/1ps
module cisa_barrel_shifter (
  input  wire logic [31:0] value,
  input  wire logic [4:0]  amount,
  input  wire logic [1:0]  kind,
  input  wire logic        carry_in,
  output logic      [31:0] result,
  output logic             carry_out
);

  logic [32:0] wide;

  always_comb begin
    wide      = 33'h0;
    result    = value;
    carry_out = carry_in;
    if (kind == cisa_pkg::shift_left_logical_op) begin
      // zero amount is a plain move, carry kept
      wide = {1'b0, value} << amount;
      if (amount != 5'h00) begin
        result    = wide[31:0];
        carry_out = wide[32];
      end
    end else if (kind == cisa_pkg::shift_right_logical_op) begin
      // zero amount encodes a shift by thirty-two
      wide = {value, 1'b0} >> amount;
      result    = (amount == 5'h00) ? 32'h0 : wide[32:1];
      carry_out = (amount == 5'h00) ? value[31] : wide[0];
    end else begin
      wide = 33'($signed({value, 1'b0}) >>> amount);
      result    = (amount == 5'h00) ? {32{value[31]}} : wide[32:1];
      carry_out = (amount == 5'h00) ? value[31] : wide[0];
    end
  end

endmodule

// *** hdl/cisa_pkg.sv ***
/*
  Constants shared by the compact instruction decoder and its arithmetic leaves:
  widths, field positions, format prefixes, opcodes, flag bit positions, reset values.
  Assumes nothing of its surroundings; it is compiled before every design module.
*/
package cisa_pkg;

  localparam int unsigned WORD_W    = 32;
  localparam int unsigned HALF_W    = 16;
  localparam int unsigned REG_CNT   = 8;
  localparam int unsigned REG_IDX_W = 3;

  // every shift, add/subtract or immediate instruction retires one clock after it is taken
  localparam int unsigned EXEC_CYCLES = 1;

  // field positions inside the halfword
  localparam int unsigned DST_LSB      = 0;
  localparam int unsigned SRC1_LSB     = 3;
  localparam int unsigned SRC2_LSB     = 6;
  localparam int unsigned SHAMT_LSB    = 6;
  localparam int unsigned SHAMT_W      = 5;
  localparam int unsigned SMALL_IMM_W  = 3;
  localparam int unsigned F2_SUB_BIT   = 9;
  localparam int unsigned F2_IMM_BIT   = 10;
  localparam int unsigned OP_LSB       = 11;
  localparam int unsigned F3_DST_LSB   = 8;
  localparam int unsigned BYTE_IMM_W   = 8;

  // format prefixes, top bits of the halfword
  localparam logic [2:0] F1_PREFIX  = 3'h0;
  localparam logic [4:0] F2_PREFIX  = 5'h03;
  localparam logic [2:0] F3_PREFIX  = 3'h1;
  localparam logic [5:0] F5_PREFIX  = 6'h11;
  localparam logic [3:0] F12_PREFIX = 4'ha;
  localparam logic [7:0] F13_PREFIX = 8'hb0;
  localparam logic [1:0] F5_ADD_OP  = 2'h0;
  localparam logic [1:0] F5_MOV_OP  = 2'h2;

  // shift-by-immediate opcodes
  localparam logic [1:0] shift_left_logical_op  = 2'h0;
  localparam logic [1:0] shift_right_logical_op = 2'h1;
  localparam logic [1:0] shift_right_arith_op   = 2'h2;

  // immediate-arithmetic opcodes
  localparam logic [1:0] move_imm_op = 2'h0;
  localparam logic [1:0] compare_op  = 2'h1;
  localparam logic [1:0] add_imm_op  = 2'h2;
  localparam logic [1:0] sub_imm_op  = 2'h3;

  // status_flags_word bit positions
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 0;

  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam logic [31:0] REG_RESET   = 32'h0;

  typedef enum logic [2:0] {
    fmt_shift,
    fmt_addsub,
    fmt_imm8,
    fmt_flag_keep,
    fmt_other
  } fmt_e;

endpackage

// *** hdl/compact_isa_format1_3_decoder.sv ***
/*
  Decoder and execute stage for the first three compact halfword formats:
  shift by immediate, add/subtract, and move/compare/add/subtract immediate.
  Holds the eight low registers and the condition flags in flip-flops.
  Assumes the fetch unit presents one halfword per valid cycle, synchronous to clock.
*/
// Notes on behaviour
// - each instruction is one 16-bit halfword standing for a full-width one
// - shift opcode 00: destination gets source shifted left by immediate
// - shift opcode 01: destination gets source shifted right, zero filled
// - shift opcode 10: destination gets source shifted right, sign filled
// - shift instructions use only low registers 0 to 7
// - all three formats update condition flags from their result
// - add/subtract op 0, register: destination gets first plus second
// - add/subtract op 0, immediate: destination gets source plus 3-bit value
// - add/subtract op 1, register: destination gets first minus second
// - add/subtract op 1, immediate: destination gets source minus 3-bit value
// - immediate opcode 00 loads the zero-extended byte into the register
// - immediate opcode 01 compares by subtraction, flags only
// - immediate opcode 10 adds the byte into the same register
// - immediate opcode 11 subtracts the byte from the same register
// - each instruction takes as many cycles as its full-width twin
// - add in high-register, address or stack-offset form keeps flags
// - register move in high-register form keeps flags
`timescale 1ns/1ps
module compact_isa_format1_3_decoder (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_halfword,
  output logic             instr_ready,
  input  wire logic [2:0]  reg_sel,
  output logic      [31:0] reg_data,
  output logic      [3:0]  status_flags_word,
  output logic             retire_pulse,
  output logic             unhandled_pulse
);

  logic [31:0] reg_q [cisa_pkg::REG_CNT];
  logic [3:0]  flags_q;
  logic [3:0]  flags_d;
  logic [31:0] reg_data_q;
  logic        retire_q;
  logic        unhandled_q;

  cisa_pkg::fmt_e fmt;
  logic [1:0]  op;
  logic [2:0]  dst_reg;
  logic [2:0]  first_src_reg;
  logic [2:0]  second_src_reg;
  logic [2:0]  imm_dst_reg;
  logic [4:0]  shift_amount_field;
  logic [2:0]  small_imm_field;
  logic [7:0]  byte_imm_field;
  logic        imm_select;
  logic        sub_select;

  logic [31:0] src_val;
  logic [31:0] shift_res;
  logic        shift_carry;
  logic [31:0] add_a;
  logic [31:0] add_b;
  logic        add_sub;
  logic [31:0] add_res;
  logic        add_carry;
  logic        add_ovf;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [31:0] wr_val;
  logic        take;

  // format decode from the top bits only
  function automatic cisa_pkg::fmt_e decode_fmt(logic [15:0] hw);
    cisa_pkg::fmt_e f;
    f = cisa_pkg::fmt_other;
    if (hw[15:11] == cisa_pkg::F2_PREFIX) begin
      f = cisa_pkg::fmt_addsub;
    end else if (hw[15:13] == cisa_pkg::F1_PREFIX) begin
      f = cisa_pkg::fmt_shift;
    end else if (hw[15:13] == cisa_pkg::F3_PREFIX) begin
      f = cisa_pkg::fmt_imm8;
    end else if (hw[15:10] == cisa_pkg::F5_PREFIX &&
                 (hw[9:8] == cisa_pkg::F5_ADD_OP || hw[9:8] == cisa_pkg::F5_MOV_OP)) begin
      f = cisa_pkg::fmt_flag_keep;
    end else if (hw[15:12] == cisa_pkg::F12_PREFIX || hw[15:8] == cisa_pkg::F13_PREFIX) begin
      f = cisa_pkg::fmt_flag_keep;
    end
    return f;
  endfunction

  // negative and zero from a result, shared by every flag-setting path
  function automatic logic [1:0] nz_of(logic [31:0] v);
    return {v[31], (v == 32'h0)};
  endfunction

  // the stage never stalls: one instruction per cycle
  assign instr_ready = 1'b1;
  assign take        = instr_valid && instr_ready;

  // field extraction
  always_comb begin
    fmt                = decode_fmt(instr_halfword);
    op                 = instr_halfword[cisa_pkg::OP_LSB +: 2];
    dst_reg            = instr_halfword[cisa_pkg::DST_LSB +: cisa_pkg::REG_IDX_W];
    first_src_reg      = instr_halfword[cisa_pkg::SRC1_LSB +: cisa_pkg::REG_IDX_W];
    second_src_reg     = instr_halfword[cisa_pkg::SRC2_LSB +: cisa_pkg::REG_IDX_W];
    imm_dst_reg        = instr_halfword[cisa_pkg::F3_DST_LSB +: cisa_pkg::REG_IDX_W];
    shift_amount_field = instr_halfword[cisa_pkg::SHAMT_LSB +: cisa_pkg::SHAMT_W];
    small_imm_field    = instr_halfword[cisa_pkg::SRC2_LSB +: cisa_pkg::SMALL_IMM_W];
    byte_imm_field     = instr_halfword[0 +: cisa_pkg::BYTE_IMM_W];
    imm_select         = instr_halfword[cisa_pkg::F2_IMM_BIT];
    sub_select         = instr_halfword[cisa_pkg::F2_SUB_BIT];
  end

  assign src_val = reg_q[first_src_reg];

  cisa_barrel_shifter u_shift (
    .value     (src_val),
    .amount    (shift_amount_field),
    .kind      (op),
    .carry_in  (flags_q[cisa_pkg::FLAG_C]),
    .result    (shift_res),
    .carry_out (shift_carry)
  );

  // adder operand selection
  always_comb begin
    add_a   = src_val;
    add_b   = reg_q[second_src_reg];
    add_sub = sub_select;
    if (fmt == cisa_pkg::fmt_imm8) begin
      add_a   = reg_q[imm_dst_reg];
      add_b   = {24'h0, byte_imm_field};
      add_sub = (op != cisa_pkg::add_imm_op);
    end else if (imm_select) begin
      add_b = {29'h0, small_imm_field};
    end
  end

  cisa_add_sub u_add (
    .op_a     (add_a),
    .op_b     (add_b),
    .subtract (add_sub),
    .sum      (add_res),
    .carry    (add_carry),
    .overflow (add_ovf)
  );

  // write-back and flag selection
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = dst_reg;
    wr_val  = add_res;
    flags_d = flags_q;
    unique case (fmt)
      cisa_pkg::fmt_shift: begin
        wr_en   = 1'b1;
        wr_val  = shift_res;
        flags_d = {nz_of(shift_res), shift_carry, flags_q[cisa_pkg::FLAG_V]};
      end
      cisa_pkg::fmt_addsub: begin
        wr_en   = 1'b1;
        flags_d = {nz_of(add_res), add_carry, add_ovf};
      end
      cisa_pkg::fmt_imm8: begin
        wr_idx = imm_dst_reg;
        if (op == cisa_pkg::move_imm_op) begin
          wr_en   = 1'b1;
          wr_val  = {24'h0, byte_imm_field};
          // immediate move keeps carry and overflow
          flags_d = {nz_of(wr_val), flags_q[1:0]};
        end else begin
          wr_en   = (op != cisa_pkg::compare_op);
          flags_d = {nz_of(add_res), add_carry, add_ovf};
        end
      end
      cisa_pkg::fmt_flag_keep: begin
        flags_d = flags_q;
      end
      cisa_pkg::fmt_other: begin
        flags_d = flags_q;
      end
    endcase
  end

  // low register file
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < cisa_pkg::REG_CNT; i++) begin
        reg_q[i] <= cisa_pkg::REG_RESET;
      end
    end else if (take && wr_en) begin
      reg_q[wr_idx] <= wr_val;
    end
  end

  // condition flags
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flags_q <= cisa_pkg::FLAGS_RESET;
    end else if (take) begin
      flags_q <= flags_d;
    end
  end

  // retire indication, single cycle like the full-width data operation
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      retire_q    <= 1'b0;
      unhandled_q <= 1'b0;
    end else begin
      retire_q    <= take && (fmt inside {cisa_pkg::fmt_shift, cisa_pkg::fmt_addsub,
                                          cisa_pkg::fmt_imm8});
      unhandled_q <= take && (fmt inside {cisa_pkg::fmt_flag_keep, cisa_pkg::fmt_other});
    end
  end

  // read port registered; sees the value before a same-cycle write
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_data_q <= cisa_pkg::REG_RESET;
    end else begin
      reg_data_q <= reg_q[reg_sel];
    end
  end

  assign reg_data          = reg_data_q;
  assign status_flags_word = flags_q;
  assign retire_pulse      = retire_q;
  assign unhandled_pulse   = unhandled_q;

  AST_ONE_CYCLE: assert property (@(posedge clock) disable iff (!rst_b)
    take |=> (retire_pulse != unhandled_pulse))
    else $error("taken halfword did not finish in one cycle");

  AST_SHIFT_LEFT: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_shift && op == cisa_pkg::shift_left_logical_op
    |=> reg_q[$past(dst_reg)] == ($past(src_val) << $past(shift_amount_field)))
    else $error("left shift result wrong");

  AST_SHIFT_RIGHT: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_shift && op == cisa_pkg::shift_right_logical_op &&
    shift_amount_field != 5'h00
    |=> reg_q[$past(dst_reg)] == ($past(src_val) >> $past(shift_amount_field)))
    else $error("logical right shift result wrong");

  AST_SHIFT_ARITH: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_shift && op == cisa_pkg::shift_right_arith_op
    |=> reg_q[$past(dst_reg)][31] == $past(src_val[31]))
    else $error("arithmetic right shift lost the sign");

  AST_ADD_PAIR: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_addsub && !sub_select && !imm_select
    |=> reg_q[$past(dst_reg)] == 32'($past(src_val) + $past(reg_q[second_src_reg])))
    else $error("register add result wrong");

  AST_ADD_SMALL: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_addsub && !sub_select && imm_select
    |=> reg_q[$past(dst_reg)] == 32'($past(src_val) + {29'h0, $past(small_imm_field)}))
    else $error("small immediate add result wrong");

  AST_SUB_PAIR: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_addsub && sub_select && !imm_select
    |=> reg_q[$past(dst_reg)] == 32'($past(src_val) - $past(reg_q[second_src_reg])))
    else $error("register subtract result wrong");

  AST_SUB_SMALL: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_addsub && sub_select && imm_select
    |=> reg_q[$past(dst_reg)] == 32'($past(src_val) - {29'h0, $past(small_imm_field)}))
    else $error("small immediate subtract result wrong");

  AST_MOVE_BYTE: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_imm8 && op == cisa_pkg::move_imm_op
    |=> reg_q[$past(imm_dst_reg)] == {24'h0, $past(byte_imm_field)} &&
        status_flags_word[1:0] == $past(flags_q[1:0]))
    else $error("byte move wrong or touched carry and overflow");

  AST_COMPARE_KEEPS: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_imm8 && op == cisa_pkg::compare_op
    |=> reg_q[$past(imm_dst_reg)] == $past(add_a) &&
        status_flags_word[cisa_pkg::FLAG_Z] == ($past(add_a) == {24'h0, $past(byte_imm_field)}))
    else $error("compare changed its register or set zero wrongly");

  AST_ADD_BYTE: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_imm8 && op == cisa_pkg::add_imm_op
    |=> reg_q[$past(imm_dst_reg)] == 32'($past(add_a) + {24'h0, $past(byte_imm_field)}))
    else $error("byte add result wrong");

  AST_SUB_BYTE: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_imm8 && op == cisa_pkg::sub_imm_op
    |=> reg_q[$past(imm_dst_reg)] == 32'($past(add_a) - {24'h0, $past(byte_imm_field)}))
    else $error("byte subtract result wrong");

  AST_FLAGS_FOLLOW: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_addsub
    |=> status_flags_word[cisa_pkg::FLAG_N] == reg_q[$past(dst_reg)][31] &&
        status_flags_word[cisa_pkg::FLAG_Z] == (reg_q[$past(dst_reg)] == 32'h0))
    else $error("flags do not follow the add/subtract result");

  AST_FLAGS_HELD: assert property (@(posedge clock) disable iff (!rst_b)
    take && fmt == cisa_pkg::fmt_flag_keep |=> $stable(status_flags_word))
    else $error("flag-keeping add or move changed the flags");

endmodule

// *** tb/compact_isa_format1_3_decoder_tb.sv ***
/*
  Self-checking bench: reference model of the low registers and flags, compared each cycle.
  Assumes the decoder package is compiled first and the fetch model sits beside the design.
*/
`timescale 1ns/1ps
module compact_isa_format1_3_decoder_tb;
  logic        clock;
  logic        rst_b;
  logic        slow;
  logic        instr_valid;
  logic [15:0] instr_halfword;
  logic        instr_ready;
  logic [2:0]  reg_sel;
  logic [31:0] reg_data;
  logic [3:0]  status_flags_word;
  logic        retire_pulse;
  logic        unhandled_pulse;
  int          error_cnt;
  int          checks_done;
  logic [31:0] regs [8];
  logic [3:0]  flags;
  logic [31:0] exp_data;
  logic        exp_ret;
  logic        exp_ok;
  logic        armed;
  int          amts [4] = '{24, 0, 1, 31};
  logic [15:0] odd_h [6] = '{16'h4448, 16'h4680, 16'ha9ff, 16'hb0ff, 16'h4280, 16'hdffe};

  compact_isa_format1_3_decoder dut_u (
    .clock             (clock),
    .rst_b             (rst_b),
    .instr_valid       (instr_valid),
    .instr_halfword    (instr_halfword),
    .instr_ready       (instr_ready),
    .reg_sel           (reg_sel),
    .reg_data          (reg_data),
    .status_flags_word (status_flags_word),
    .retire_pulse      (retire_pulse),
    .unhandled_pulse   (unhandled_pulse)
  );

  fetch_model fetch_u (
    .clock          (clock),
    .rst_b          (rst_b),
    .slow           (slow),
    .instr_valid    (instr_valid),
    .instr_halfword (instr_halfword)
  );

  initial clock = 1'b0;
  always #4 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // reference execute; ok low for halfwords outside the three formats
  task automatic execute(input logic [15:0] h, output logic ok);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [32:0] s;
    logic        sub;
    logic        ar;
    int          n;
    ok  = 1'b1;
    ar  = 1'b0;
    sub = h[11];
    n   = int'(h[10:6]);
    a   = regs[h[5:3]];
    b   = {24'h0, h[7:0]};
    r   = b;
    if (h[15:11] == 5'h03) begin
      ar  = 1'b1;
      sub = h[9];
      b   = h[10] ? {29'h0, h[8:6]} : regs[h[8:6]];
    end else if (h[15:13] == 3'h0) begin
      if (h[12:11] == 2'h0) r = a << n;
      else if (h[12:11] == 2'h1) r = (n == 0) ? 32'h0 : a >> n;
      else r = (n == 0) ? {32{a[31]}} : 32'($signed(a) >>> n);
      if (n != 0) flags[cisa_pkg::FLAG_C] = a[(h[12:11] == 2'h0) ? 32 - n : n - 1];
      else if (h[12:11] != 2'h0) flags[cisa_pkg::FLAG_C] = a[31];
    end else if (h[15:13] == 3'h1) begin
      a  = regs[h[10:8]];
      ar = (h[12:11] != 2'h0);
    end else begin
      ok = 1'b0;
      return;
    end
    if (ar) begin
      s = sub ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
      r = s[31:0];
      flags[cisa_pkg::FLAG_C] = s[32];
      flags[cisa_pkg::FLAG_V] = (a[31] == (b[31] ^ sub)) && (r[31] != a[31]);
    end
    flags[cisa_pkg::FLAG_N] = r[31];
    flags[cisa_pkg::FLAG_Z] = (r == 32'h0);
    if (h[15:13] != 3'h1) regs[h[2:0]] = r;
    else if (h[12:11] != 2'h1) regs[h[10:8]] = r;
  endtask

  function automatic logic [15:0] rnd_instr();
    logic [15:0] h;
    h = 16'($urandom);
    case ($urandom_range(3, 0))
      0: h[15:13] = 3'h0;
      1: h[15:11] = 5'h03;
      2: h[15:13] = 3'h1;
      default: ;
    endcase
    return h;
  endfunction

  task automatic drain();
    int t;
    t = 0;
    while (fetch_u.depth() > 0 && t < 20000) begin
      @(posedge clock);
      t++;
    end
    if (t >= 20000) error_cnt++;
    repeat (3) @(posedge clock);
  endtask

  // expectations from the values sampled at this edge, compared mid-cycle
  always @(posedge clock) begin
    exp_ret = 1'b0;
    exp_ok  = 1'b0;
    if (!rst_b) begin
      foreach (regs[i]) regs[i] = cisa_pkg::REG_RESET;
      flags    = cisa_pkg::FLAGS_RESET;
      exp_data = 32'h0;
    end else begin
      exp_data = regs[reg_sel];
      if (instr_valid) begin
        execute(instr_halfword, exp_ok);
        exp_ret = 1'b1;
      end
    end
    armed = 1'b1;
    reg_sel <= 3'($urandom);
  end

  always @(negedge clock) begin
    if (armed) begin
      check(reg_data, exp_data);
      check({28'h0, status_flags_word}, {28'h0, flags});
      check({30'h0, retire_pulse, unhandled_pulse}, {30'h0, exp_ret & exp_ok, exp_ret & ~exp_ok});
      check({31'h0, instr_ready}, 32'h1);
    end
  end

  initial begin
    #400000;
    error_cnt++;
    close_out();
  end

  initial begin
    void'($urandom(32'hac87));
    rst_b       = 1'b0;
    slow        = 1'b0;
    reg_sel     = 3'h0;
    armed       = 1'b0;
    error_cnt   = 0;
    checks_done = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // seed every low register, then every opcode back to back, shift counts 24, 0, 1 and 31
    for (int i = 0; i < 8; i++) fetch_u.push({5'h04, i[2:0], 8'h80 + 8'(i * 37)});
    foreach (amts[j])
      for (int op = 0; op < 3; op++) fetch_u.push({3'h0, 2'(op), 5'(amts[j]), 3'(j), 3'(op + j)});
    for (int op = 0; op < 4; op++) begin
      fetch_u.push({5'h03, 2'(op), 3'(op + 5), 3'(op), 3'(op + 1)});
      fetch_u.push({3'h1, 2'(op), 3'(op), 8'h00});
      fetch_u.push({3'h1, 2'(op), 3'(op + 4), 8'hff});
      // flag-keeping forms right after a flag update
      fetch_u.push(odd_h[op]);
    end
    foreach (odd_h[k]) fetch_u.push(odd_h[k]);
    drain();
    for (int k = 0; k < 1500; k++) fetch_u.push(rnd_instr());
    drain();
    // stalling fetch, with a reset landing mid-stream
    slow <= 1'b1;
    for (int k = 0; k < 1500; k++) fetch_u.push(rnd_instr());
    repeat (300) @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    drain();
    close_out();
  end
endmodule

// *** tb/fetch_model.sv ***
/*
  Behavioural instruction fetch unit feeding the compact decoder.
  Assumes the bench pushes halfwords with push and seeds the random source once.
*/
`timescale 1ns/1ps
module fetch_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        slow,
  output logic             instr_valid,
  output logic      [15:0] instr_halfword
);
  logic [15:0] pend_q [$];

  initial begin
    instr_valid    = 1'b0;
    instr_halfword = 16'h0000;
  end

  task automatic push(input logic [15:0] h);
    pend_q.push_back(h);
  endtask

  function automatic int depth();
    return pend_q.size();
  endfunction

  // one whole halfword per valid cycle, random gaps when slow
  always @(posedge clock) begin
    if (rst_b && pend_q.size() > 0 && (!slow || $urandom_range(1, 0) == 1)) begin
      instr_valid    <= 1'b1;
      instr_halfword <= pend_q.pop_front();
    end else begin
      instr_valid    <= 1'b0;
      // idle lines invert the held word every cycle, so a stale decode shows up
      instr_halfword <= ~instr_halfword;
    end
  end
endmodule
